// file: shared/wsc_pkg.sv
// Notes on behaviour
// - Service register: window select 7:6, key 5:1, clock-monitor select 0.
// - Every service write must carry key 01100 in bits 5 to 1.
// - Lower window limit is 2048 cycles for every window selection.
// - Upper limit from bits 7:6: 8k, 16k, 32k or 64k cycles.
// - Bit 0 written 1 enables the clock monitor, 0 disables it.
// - Both detectors inhibited in reset; afterwards max window, monitor enabled.
// - Only the first keyed write after reset configures, irrevocably.
// - Later writes compare bits 7 to 0 with stored values; mismatch errs.
// - Service before lower limit errs; each service restarts the window.
// - Missing a service before the upper limit raises a fault.
// - The first configuring write also counts as a service.
// - Fault drives pin low, holds 16-32 cycles after pin reads low.
// - Window restarts when the fault pin returns high.
// - Service writes are ignored while the fault is active.
// - Clock error drives pin low; released 16-32 cycles after recovery.
// - Monitor accepts 10 kHz or more, always rejects below 10 Hz.
// - Reads of the service register return zeros in the key field.
// - Window detector stops in halt and idle; clock monitor runs in idle, stops counting in halt.
// - After halt: resume if RC option and no clock delay, else restart.
// - Leaving idle performs an automatic service.
// - Idle counter not reset; tick pending set every 4096 cycles, software clears.
// - Initial service may come anywhere in the 65536-cycle reset window.
// - Key, window and monitor fields must all match or a fault follows.
package wsc_pkg;
	localparam logic [7:0] SVC_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam int SVC_SEL_HI = 7;
	localparam int SVC_SEL_LO = 6;
	localparam int SVC_KEY_HI = 5;
	localparam int SVC_KEY_LO = 1;
	localparam int SVC_CME_BIT = 0;
	localparam int CTRL_CLOCK_DELAY_SELECT_BIT = 0;
	localparam int CTRL_TICK_BIT = 1;
	localparam logic [4:0] SVC_KEY = 5'h0C;
	localparam logic [1:0] SEL_RST = 2'h3;
	localparam logic CME_RST = 1'b1;
	localparam logic CLOCK_DELAY_SELECT_RST = 1'b0;
	// RC oscillator mask option is fitted in this build
	localparam logic RC_OSC_FITTED = 1'b1;
	localparam logic [16:0] LOWER_CYC = 17'h0_0800;
	localparam logic [16:0] UPPER_BASE_CYC = 17'h0_2000;
	localparam logic [4:0] FLT_HOLD_CYC = 5'h10;
	localparam int IDLE_TICK_BIT = 12;
	localparam int CLK_HZ = 10_000_000;
	localparam int REF_PERIOD_US = 1000;
	localparam int CM_MIN_HZ = 10_000;
	// Half the nominal count at 10 kHz, so phase jitter never rejects it
	localparam logic [7:0] CM_MIN_CYC =
		8'((REF_PERIOD_US * (CM_MIN_HZ / 1000)) / 2000);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum {FLT_IDLE, FLT_PULL, FLT_HOLD, FLT_WAIT_HIGH} wsc_flt_e;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} wsc_ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} wsc_ahb_rsp_s;

	typedef struct packed {
		logic drv_out;
		logic drv_oe;
	} wsc_pin_s;
endpackage : wsc_pkg

// file: src/wsc_top.sv
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module wsc_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire wsc_pkg::wsc_ahb_req_s ahb_req,
	output wsc_pkg::wsc_ahb_rsp_s ahb_rsp,
	input wire logic halt_mode,
	input wire logic idle_mode,
	input wire logic ref_tick,
	input wire logic fault_pin_in,
	output wsc_pkg::wsc_pin_s fault_output,
	output logic idle_tick_pending
);
	import wsc_pkg::*;

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_ofs;
		logic [31:0] hrdata;
		logic configured;
		logic lower_exempt;
		logic [1:0] sel;
		logic cme;
		logic clock_delay_select;
		logic [16:0] win_cnt;
		logic halt_d;
		logic idle_d;
		wsc_flt_e flt;
		logic [4:0] flt_cnt;
		logic [7:0] cm_cnt;
		logic cm_err;
		logic cm_hold;
		logic [4:0] cm_rel_cnt;
		logic tick_pend;
		logic drive;
	} wsc_state_s;

	wsc_state_s s_q;
	wsc_state_s s_d;

	// Free running, deliberately outside reset
	logic [15:0] idle_counter = 16'h0000;
	always_ff @(posedge core_clk) begin
		idle_counter <= idle_counter + 16'h0001;
	end

	logic addr_ok;
	logic wr_svc;
	logic wr_ctrl;
	logic svc_err;
	logic wd_err;
	logic idle_tick;
	logic [16:0] upper_lim;
	logic [7:0] wd8;
	logic [7:0] ofs;

	always_comb begin
		s_d = s_q;
		ofs = ahb_req.haddr[7:0];
		addr_ok = ahb_req.hsel && ahb_req.hready &&
			(ahb_req.htrans == HTRANS_NONSEQ);
		wd8 = ahb_req.hwdata[7:0];
		wr_svc = s_q.wr_pend && (s_q.wr_ofs == SVC_OFS);
		wr_ctrl = s_q.wr_pend && (s_q.wr_ofs == CTRL_OFS);
		upper_lim = UPPER_BASE_CYC << s_q.sel;
		svc_err = 1'b0;
		wd_err = 1'b0;
		idle_tick = (idle_counter[IDLE_TICK_BIT-1:0] == 12'hFFF);

		// Address phase; read data latched so it stands in the data phase
		s_d.wr_pend = addr_ok && ahb_req.hwrite;
		s_d.wr_ofs = ofs;
		s_d.hrdata = 32'h0000_0000;
		if (addr_ok && !ahb_req.hwrite) begin
			case (ofs)
				SVC_OFS: s_d.hrdata = {24'h00_0000, s_q.sel, 5'h00, s_q.cme};
				CTRL_OFS: s_d.hrdata = {30'h0000_0000, s_q.tick_pend, s_q.clock_delay_select};
				STAT_OFS: s_d.hrdata = {27'h000_0000, s_q.cm_err,
					s_q.drive, s_q.configured, s_q.flt != FLT_IDLE,
					s_q.lower_exempt};
				default: s_d.hrdata = 32'h0000_0000;
			endcase
		end

		if (wr_ctrl) begin
			s_d.clock_delay_select = wd8[CTRL_CLOCK_DELAY_SELECT_BIT];
		end

		// Window detector, inhibited in halt and idle
		s_d.halt_d = halt_mode;
		s_d.idle_d = idle_mode;
		if (halt_mode || idle_mode) begin
			s_d.win_cnt = s_q.win_cnt;
		end else if (s_q.halt_d) begin
			if (!(RC_OSC_FITTED && !s_q.clock_delay_select)) begin
				s_d.win_cnt = 17'h0_0000;
			end
		end else if (s_q.idle_d) begin
			s_d.win_cnt = 17'h0_0000;
		end else if (s_q.flt == FLT_IDLE) begin
			if (wr_svc) begin
				if (!s_q.configured) begin
					if (wd8[SVC_KEY_HI:SVC_KEY_LO] == SVC_KEY) begin
						s_d.configured = 1'b1;
						s_d.sel = wd8[SVC_SEL_HI:SVC_SEL_LO];
						s_d.cme = wd8[SVC_CME_BIT];
						s_d.lower_exempt = 1'b0;
						s_d.win_cnt = 17'h0_0000;
					end else begin
						svc_err = 1'b1;
					end
				end else if (wd8 != {s_q.sel, SVC_KEY, s_q.cme}) begin
					svc_err = 1'b1;
				end else if (s_q.win_cnt < LOWER_CYC && !s_q.lower_exempt) begin
					svc_err = 1'b1;
				end else begin
					s_d.win_cnt = 17'h0_0000;
					s_d.lower_exempt = 1'b0;
				end
			end else if (s_q.win_cnt >= upper_lim - 17'h0_0001) begin
				wd_err = 1'b1;
			end else begin
				s_d.win_cnt = s_q.win_cnt + 17'h0_0001;
			end
		end
		// Service writes during an active fault fall through untouched

		case (s_q.flt)
			FLT_IDLE: begin
				if (svc_err || wd_err) begin
					s_d.flt = FLT_PULL;
				end
			end
			FLT_PULL: begin
				s_d.flt_cnt = 5'h00;
				if (!fault_pin_in) begin
					s_d.flt = FLT_HOLD;
				end
			end
			FLT_HOLD: begin
				s_d.flt_cnt = s_q.flt_cnt + 5'h01;
				if (s_q.flt_cnt == FLT_HOLD_CYC - 5'h01) begin
					s_d.flt = FLT_WAIT_HIGH;
				end
			end
			FLT_WAIT_HIGH: begin
				if (fault_pin_in) begin
					s_d.flt = FLT_IDLE;
					s_d.win_cnt = 17'h0_0000;
				end
			end
			default: s_d.flt = FLT_IDLE;
		endcase

		// Clock monitor: instruction cycles stop in halt, so halt starves it
		if (ref_tick) begin
			s_d.cm_cnt = 8'h00;
			s_d.cm_err = s_q.cme && (s_q.cm_cnt < CM_MIN_CYC);
		end else if (!halt_mode && s_q.cm_cnt != 8'hFF) begin
			s_d.cm_cnt = s_q.cm_cnt + 8'h01;
		end
		if (!s_q.cme) begin
			s_d.cm_err = 1'b0;
		end
		if (s_q.cm_err) begin
			s_d.cm_hold = 1'b1;
			s_d.cm_rel_cnt = 5'h00;
		end else if (s_q.cm_hold) begin
			s_d.cm_rel_cnt = s_q.cm_rel_cnt + 5'h01;
			if (s_q.cm_rel_cnt == FLT_HOLD_CYC - 5'h01) begin
				s_d.cm_hold = 1'b0;
			end
		end

		s_d.drive = (s_d.flt == FLT_PULL) || (s_d.flt == FLT_HOLD) ||
			s_d.cm_err || s_d.cm_hold;

		// Set wins over a software clear in the same cycle
		if (wr_ctrl && wd8[CTRL_TICK_BIT]) begin
			s_d.tick_pend = 1'b0;
		end
		if (idle_tick) begin
			s_d.tick_pend = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.sel <= SEL_RST;
			s_q.cme <= CME_RST;
			s_q.clock_delay_select <= CLOCK_DELAY_SELECT_RST;
			s_q.lower_exempt <= 1'b1;
			s_q.flt <= FLT_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign ahb_rsp.hrdata = s_q.hrdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign fault_output.drv_out = 1'b0;
	assign fault_output.drv_oe = s_q.drive;
	assign idle_tick_pending = s_q.tick_pend;
endmodule : wsc_top

// file: tb/wsc_pin_model.sv
`timescale 1ns/1ns
module wsc_pin_model (
	input wire wsc_pkg::wsc_pin_s fault_output,
	input wire logic ext_low,
	output logic fault_pin_in
);
	import wsc_pkg::*;
	// Pull-up wins whenever nobody pulls low, so a released pin reads high
	assign fault_pin_in = !(fault_output.drv_oe || ext_low);
endmodule : wsc_pin_model

// file: tb/wsc_top_asserts.sv
`timescale 1ns/1ns
module wsc_top_asserts (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire wsc_pkg::wsc_ahb_req_s ahb_req,
	input wire wsc_pkg::wsc_ahb_rsp_s ahb_rsp,
	input wire logic fault_pin_in,
	input wire wsc_pkg::wsc_pin_s fault_output,
	input wire logic idle_tick_pending
);
	import wsc_pkg::*;
	logic rd_q, ws_q, wc_q, a, w, s, oe;
	assign a = ahb_req.hsel && ahb_req.hready &&
		ahb_req.htrans == HTRANS_NONSEQ;
	assign w = a && ahb_req.hwrite;
	assign s = ahb_req.haddr[7:0] == SVC_OFS;
	assign oe = fault_output.drv_oe;
	// Flags mark the data phase, where hwdata and hrdata stand
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			{rd_q, ws_q, wc_q} <= 3'h0;
		else
			{rd_q, ws_q, wc_q} <= {a && !w && s, w && s,
				w && ahb_req.haddr[7:0] == CTRL_OFS};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	AST_RDY: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
		else $error("bus answer not ready or not okay");
	AST_OD: assert property (!fault_output.drv_out)
		else $error("fault output drives high");
	AST_QUIET: assert property ($rose(arst_n) |-> !oe && !idle_tick_pending)
		else $error("outputs active right after reset");
	AST_HOLD: assert property ($rose(oe) |-> ##16 oe)
		else $error("fault drive released too early");
	AST_REL: assert property ($fell(oe) |-> $past(oe, 17))
		else $error("fault drive shorter than hold time");
	AST_KEYRD: assert property (rd_q |-> ahb_rsp.hrdata[5:1] == 5'h00)
		else $error("key field visible on read");
	AST_STICKY: assert property (idle_tick_pending && !wc_q |=> idle_tick_pending)
		else $error("tick flag cleared without a write");
	AST_BADKEY: assert property (ws_q && ahb_req.hwdata[5:1] != SVC_KEY &&
		fault_pin_in && !oe && !$past(oe) |=> oe)
		else $error("bad key did not raise the fault");
	AST_C_FLT: cover property ($rose(oe));
	AST_C_TICK: cover property ($rose(idle_tick_pending));
	AST_C_RD: cover property (rd_q);
endmodule : wsc_top_asserts
bind wsc_top wsc_top_asserts wsc_top_asserts_inst (.core_clk(core_clk),
	.arst_n(arst_n), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
	.fault_pin_in(fault_pin_in), .fault_output(fault_output),
	.idle_tick_pending(idle_tick_pending));

// file: tb/window_supervisor_clock_check_tb_top.sv
`timescale 1ns/1ns
module window_supervisor_clock_check_tb_top;
	import wsc_pkg::*;
	logic core_clk, arst_n, halt_mode, idle_mode, ref_tick, pin, pnd;
	wsc_ahb_req_s m, req;
	wsc_ahb_rsp_s rsp;
	wsc_pin_s fo;
	int fail_count, checks, cyc, n;
	logic [31:0] rv;
	assign req = {m[$bits(m)-1:1], rsp.hreadyout};
	wsc_top wsc_top_inst (.core_clk(core_clk), .arst_n(arst_n),
		.ahb_req(req), .ahb_rsp(rsp), .halt_mode(halt_mode),
		.idle_mode(idle_mode), .ref_tick(ref_tick), .fault_pin_in(pin),
		.fault_output(fo), .idle_tick_pending(pnd));
	wsc_pin_model wsc_pin_model_inst (.fault_output(fo), .ext_low(1'h0),
		.fault_pin_in(pin));
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic cy(input int k);
		repeat (k) @(posedge core_clk);
	endtask : cy
	task automatic chk(input string t, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", t, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, d);
		m.hsel <= 1'h1;
		m.haddr <= {24'h00_0000, a};
		m.htrans <= HTRANS_NONSEQ;
		m.hwrite <= wr;
		do @(posedge core_clk); while (rsp.hreadyout !== 1'h1);
		m.htrans <= 2'h0;
		m.hwdata <= {24'h00_0000, d};
		do @(posedge core_clk); while (rsp.hreadyout !== 1'h1);
		rv = rsp.hrdata;
	endtask : bus
	task automatic oe(input logic v, input int k, input string t);
		for (int i = 0; i < k && fo.drv_oe !== v; i++) cy(1);
		chk(t, {31'h0, v}, {31'h0, fo.drv_oe});
	endtask : oe
	task automatic tick();
		ref_tick <= 1'h1;
		cy(1);
		ref_tick <= 1'h0;
	endtask : tick
	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial begin
		m = '0;
		m.hsize = 3'h2;
		{arst_n, halt_mode, idle_mode, ref_tick} = 4'h0;
		cy(8);
		arst_n <= 1'h1;
		bus(1'h0, SVC_OFS, 8'h00);
		chk("svc_rst", 32'h0000_00c1, rv);
		bus(1'h1, SVC_OFS, 8'h18);
		bus(1'h0, SVC_OFS, 8'h00);
		chk("svc_cfg", 32'h0000_0000, rv);
		oe(1'h0, 0, "cfg_early");
		$display("test config done");
		cy(3000);
		bus(1'h1, SVC_OFS, 8'hd9);
		oe(1'h1, 4, "mismatch");
		n = 0;
		while (fo.drv_oe === 1'h1 && n < 99) begin
			cy(1);
			n++;
		end
		chk("hold", 32'h0000_0011, n);
		cy(2);
		bus(1'h1, SVC_OFS, 8'h18);
		oe(1'h1, 4, "early");
		oe(1'h0, 40, "early_rel");
		$display("test faults done");
		cy(2100);
		bus(1'h1, SVC_OFS, 8'h18);
		cy(8180);
		oe(1'h0, 0, "in_window");
		oe(1'h1, 20, "late");
		oe(1'h0, 40, "late_rel");
		cy(2100);
		bus(1'h1, SVC_OFS, 8'h18);
		cy(3000);
		// Long idle would overrun the window if the count kept running
		idle_mode <= 1'h1;
		cy(20000);
		oe(1'h0, 0, "idle");
		idle_mode <= 1'h0;
		cy(2);
		bus(1'h1, SVC_OFS, 8'h18);
		oe(1'h1, 4, "idle_exit");
		chk("tick", 32'h1, {31'h0, pnd});
		bus(1'h1, CTRL_OFS, 8'h02);
		cy(1);
		chk("tick_clr", 32'h0, {31'h0, pnd});
		oe(1'h0, 40, "idle_rel");
		$display("test window done");
		arst_n <= 1'h0;
		cy(2);
		arst_n <= 1'h1;
		cy(100);
		tick();
		cy(2);
		tick();
		oe(1'h1, 4, "clk_err");
		cy(40);
		oe(1'h1, 0, "clk_stay");
		tick();
		oe(1'h0, 40, "clk_rec");
		$display("test clock monitor done");
		cy(2);
		bus(1'h1, SVC_OFS, 8'hc3);
		oe(1'h1, 4, "bad_key");
		oe(1'h0, 40, "bad_key_rel");
		cy(2);
		bus(1'h1, SVC_OFS, 8'h19);
		bus(1'h0, SVC_OFS, 8'h00);
		chk("svc_cfg2", 32'h0000_0001, rv);
		$display("test bad key done");
		cy(5000);
		// Monitor keeps watching in halt; ticks with no cycles between fail
		halt_mode <= 1'h1;
		tick();
		cy(5);
		tick();
		oe(1'h1, 4, "halt_clk");
		halt_mode <= 1'h0;
		cy(10);
		tick();
		oe(1'h0, 40, "halt_clk_rec");
		// Resumed count expires near 3200 cycles, a restart near 8200
		cy(3000);
		oe(1'h0, 0, "halt_resume");
		oe(1'h1, 300, "halt_late");
		oe(1'h0, 40, "halt_rel");
		$display("test halt done");
		print_verdict();
	end
endmodule : window_supervisor_clock_check_tb_top
